// ---- inc/sfp_params.svh ----
// constants of the discoverable-parameter read block
// assumes inclusion by bare name from the design files
`ifndef SFP_PARAMS_SVH
`define SFP_PARAMS_SVH

// instruction framing
`define SFP_OPCODE        8'h5A
`define SFP_CMD_BITS      5'h08
`define SFP_ADDR_BITS     5'h18
`define SFP_DUMMY_BITS    5'h08
`define SFP_DATA_BITS     5'h08

// parameter space, wraps to zero past its top
`define SFP_ADDR_W        8
`define SFP_ADDR_ZERO     8'h00
`define SFP_ADDR_STEP     8'h01

// parameter content
`define SFP_SIG_B0        8'h53
`define SFP_SIG_B1        8'h46
`define SFP_SIG_B2        8'h44
`define SFP_SIG_B3        8'h50
`define SFP_REV_MINOR     8'h00
`define SFP_REV_MAJOR     8'h01
`define SFP_HDR_COUNT     8'h00
`define SFP_UNUSED        8'hFF
`define SFP_TBL_ID        8'h00
`define SFP_TBL_MINOR     8'h00
`define SFP_TBL_MAJOR     8'h01
`define SFP_TBL_LEN_DW    8'h09
`define SFP_TBL_PTR_B0    8'h30
`define SFP_TBL_PTR_B1    8'h00
`define SFP_TBL_PTR_B2    8'h00
`define SFP_TBL_B30       8'hED
`define SFP_TBL_B31       8'h20
`define SFP_TBL_B32       8'hB1
`define SFP_TBL_B33       8'hFF
`define SFP_TBL_B34       8'hFF
`define SFP_TBL_B35       8'hFF
`define SFP_TBL_B36       8'hFF
`define SFP_TBL_B37       8'h03
`define SFP_TBL_B38       8'h5F
`define SFP_TBL_B39       8'hEB

`endif

// ---- inc/sfp_pkg.sv ----
// types of the discoverable-parameter read block
// assumes sfp_params.svh holds all numeric constants
package sfp_pkg;
   typedef enum logic [2:0] {
      ST_CMD    = 3'h0,
      ST_ADDR   = 3'h1,
      ST_DUMMY  = 3'h2,
      ST_DATA   = 3'h3,
      ST_IGNORE = 3'h4
   } sfp_state_t;
endpackage : sfp_pkg

// ---- logic/sfp_read.sv ----
// serial discoverable-parameter read instruction, device side
// assumes sclk is the host serial clock (mode 0 or 3), stopped when
// cs_n is high; busy_in comes from device logic on clk
`timescale 1ns/1ps
`include "sfp_params.svh"

//
// Overview of operation
// R1 - opcode 5Ah right after chip select falls starts a parameter read
// R2 - three address bytes, msb first, then one dummy byte, then data
// R3 - opcode, address and dummy bits sampled on serial clock rising edge
// R4 - each data bit driven on the serial clock falling edge
// R5 - any byte address is a legal start, no alignment
// R6 - address advances by one after each complete data byte
// R7 - address wraps to zero past the top and streaming continues
// R8 - chip select high at any time stops driving and ends the read
// R9 - read refused while erase, program or write runs; cycle untouched
// R10 - bytes 0 to 3 hold signature 50444653h, lsb first
// R11 - byte 4 minor revision 00h, byte 5 major revision 01h
// R12 - byte 6 is 00h, one header; bytes 7 and 15 read FFh
// R13 - header gives id 00h, minor 00h, major 01h at bytes 8 to 10
// R14 - byte 11 gives table length of nine double words
// R15 - bytes 12 to 14 give table location 000030h, lsb first
// R16 - byte 30h bits 1:0 give 4 KB erase, bit 2 byte writes
// R17 - byte 30h bits 4:3 are 01b for opcode 50h, bits 7:5 ones
// R18 - byte 31h returns the 4 KB erase opcode 20h
// R19 - first double word bit 16 set, dual output fast read
// R20 - first double word bits 18:17 are 00b, three-byte addressing
// R21 - byte 39h returns the quad fast read opcode EBh
// R22 - undefined parameter addresses return FFh
module sfp_read (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ce,
   input  wire logic busy_in,
   input  wire logic sclk,
   input  wire logic cs_n,
   input  wire logic mosi,
   output logic      miso,
   output logic      miso_oe,
   output logic      read_active,
   output logic      read_rejected
);

   // link reset: chip release or device reset
   logic                   link_rst_n;

   // clk domain
   logic                   busy_reg;
   logic                   busy_next;
   logic [1:0]             flag_s1_reg;
   logic [1:0]             flag_s2_reg;
   logic [1:0]             flag_s1_next;
   logic [1:0]             flag_s2_next;
   logic                   active_reg;
   logic                   active_next;
   logic                   rejected_reg;
   logic                   rejected_next;

   // link domain, rising edge
   logic                   busy_l1_reg;
   logic                   busy_l2_reg;
   logic                   busy_l1_next;
   logic                   busy_l2_next;
   sfp_pkg::sfp_state_t    state_reg;
   sfp_pkg::sfp_state_t    state_next;
   logic [4:0]             cnt_reg;
   logic [4:0]             cnt_next;
   logic [6:0]             shift_reg;
   logic [6:0]             shift_next;
   logic [`SFP_ADDR_W-1:0] addr_reg;
   logic [`SFP_ADDR_W-1:0] addr_next;
   logic [1:0]             link_flags_reg;
   logic [1:0]             link_flags_next;
   logic [7:0]             rom_q;

   // link domain, falling edge
   logic                   miso_reg;
   logic                   miso_next;
   logic                   oe_reg;
   logic                   oe_next;
   logic [2:0]             bit_idx;

   function automatic logic phase_done(
      input logic [4:0] cnt,
      input logic [4:0] len);
      phase_done = (cnt == (len - 5'h01));
   endfunction : phase_done

   assign link_rst_n = rst_n & ~cs_n; // R8

   // ---------------- clk domain ----------------

   always_comb begin
      busy_next     = busy_reg;
      flag_s1_next  = flag_s1_reg;
      flag_s2_next  = flag_s2_reg;
      active_next   = active_reg;
      rejected_next = rejected_reg;
      if (ce) begin
         busy_next     = busy_in;
         flag_s1_next  = link_flags_reg;
         flag_s2_next  = flag_s1_reg;
         active_next   = flag_s2_reg[0];
         rejected_next = flag_s2_reg[1];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_reg     <= 1'b0;
         flag_s1_reg  <= 2'h0;
         flag_s2_reg  <= 2'h0;
         active_reg   <= 1'b0;
         rejected_reg <= 1'b0;
      end else begin
         busy_reg     <= busy_next;
         flag_s1_reg  <= flag_s1_next;
         flag_s2_reg  <= flag_s2_next;
         active_reg   <= active_next;
         rejected_reg <= rejected_next;
      end
   end

   // ---------------- link domain, rising edge ----------------

   always_comb begin
      busy_l1_next = busy_reg;
      busy_l2_next = busy_l1_reg;
   end

   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg + 5'h01;
      shift_next = {shift_reg[5:0], mosi}; // R3
      addr_next  = addr_reg;
      case (state_reg)
         sfp_pkg::ST_CMD: begin
            if (phase_done(cnt_reg, `SFP_CMD_BITS)) begin
               cnt_next = 5'h00;
               if (({shift_reg, mosi} == `SFP_OPCODE) && // R1
                   !busy_l2_reg) begin // R9
                  state_next = sfp_pkg::ST_ADDR;
               end else begin
                  state_next = sfp_pkg::ST_IGNORE; // R9
               end
            end
         end
         sfp_pkg::ST_ADDR: begin
            // low byte of the 24-bit address is what remains; R5
            addr_next = {addr_reg[`SFP_ADDR_W-2:0], mosi}; // R2
            if (phase_done(cnt_reg, `SFP_ADDR_BITS)) begin
               cnt_next   = 5'h00;
               state_next = sfp_pkg::ST_DUMMY; // R2
            end
         end
         sfp_pkg::ST_DUMMY: begin
            if (phase_done(cnt_reg, `SFP_DUMMY_BITS)) begin
               cnt_next   = 5'h00;
               state_next = sfp_pkg::ST_DATA; // R2
            end
         end
         sfp_pkg::ST_DATA: begin
            if (phase_done(cnt_reg, `SFP_DATA_BITS)) begin
               cnt_next  = 5'h00;
               addr_next = addr_reg + `SFP_ADDR_STEP; // R6 R7
            end
         end
         sfp_pkg::ST_IGNORE: begin
            cnt_next = cnt_reg;
         end
         default: begin
            cnt_next   = cnt_reg;
            state_next = sfp_pkg::ST_IGNORE;
         end
      endcase
      link_flags_next[0] = (state_next == sfp_pkg::ST_DATA);
      link_flags_next[1] = link_flags_reg[1] |
         ((state_reg == sfp_pkg::ST_CMD) &&
          (state_next == sfp_pkg::ST_IGNORE) &&
          ({shift_reg, mosi} == `SFP_OPCODE));
   end

   always_ff @(posedge sclk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         busy_l1_reg    <= 1'b0;
         busy_l2_reg    <= 1'b0;
         state_reg      <= sfp_pkg::ST_CMD;
         cnt_reg        <= 5'h00;
         shift_reg      <= 7'h00;
         addr_reg       <= `SFP_ADDR_ZERO;
         link_flags_reg <= 2'h0;
      end else begin
         busy_l1_reg    <= busy_l1_next;
         busy_l2_reg    <= busy_l2_next;
         state_reg      <= state_next;
         cnt_reg        <= cnt_next;
         shift_reg      <= shift_next;
         addr_reg       <= addr_next;
         link_flags_reg <= link_flags_next;
      end
   end

   // read data holds the byte at addr_reg as of the last rising edge of sclk
   sfp_rom u_rom (
      .clk     (sclk),
      .rd_addr (addr_next),
      .rd_data (rom_q)
   );

   // ---------------- link domain, falling edge ----------------

   always_comb begin
      bit_idx   = 3'h7 - cnt_reg[2:0];
      miso_next = 1'b0;
      oe_next   = 1'b0;
      if (state_reg == sfp_pkg::ST_DATA) begin
         miso_next = rom_q[bit_idx]; // R4
         oe_next   = 1'b1;
      end
   end

   always_ff @(negedge sclk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         miso_reg <= 1'b0; // R8
         oe_reg   <= 1'b0; // R8
      end else begin
         miso_reg <= miso_next; // R4
         oe_reg   <= oe_next;
      end
   end

   assign miso          = miso_reg;
   assign miso_oe       = oe_reg;
   assign read_active   = active_reg;
   assign read_rejected = rejected_reg;

endmodule : sfp_read

// ---- logic/sfp_rom.sv ----
// parameter table with registered read data
// assumes rd_addr is stable at each rising edge of clk
`timescale 1ns/1ps
`include "sfp_params.svh"

module sfp_rom (
   input  wire logic                     clk,
   input  wire logic [`SFP_ADDR_W-1:0]   rd_addr,
   output logic      [7:0]               rd_data
);

   logic [7:0] data_next;

   function automatic logic [7:0] table_byte(
      input logic [`SFP_ADDR_W-1:0] a);
      case (a)
         8'h00: table_byte = `SFP_SIG_B0;     // R10
         8'h01: table_byte = `SFP_SIG_B1;     // R10
         8'h02: table_byte = `SFP_SIG_B2;     // R10
         8'h03: table_byte = `SFP_SIG_B3;     // R10
         8'h04: table_byte = `SFP_REV_MINOR;  // R11
         8'h05: table_byte = `SFP_REV_MAJOR;  // R11
         8'h06: table_byte = `SFP_HDR_COUNT;  // R12
         8'h07: table_byte = `SFP_UNUSED;     // R12
         8'h08: table_byte = `SFP_TBL_ID;     // R13
         8'h09: table_byte = `SFP_TBL_MINOR;  // R13
         8'h0A: table_byte = `SFP_TBL_MAJOR;  // R13
         8'h0B: table_byte = `SFP_TBL_LEN_DW; // R14
         8'h0C: table_byte = `SFP_TBL_PTR_B0; // R15
         8'h0D: table_byte = `SFP_TBL_PTR_B1; // R15
         8'h0E: table_byte = `SFP_TBL_PTR_B2; // R15
         8'h0F: table_byte = `SFP_UNUSED;     // R12
         8'h30: table_byte = `SFP_TBL_B30;    // R16 R17
         8'h31: table_byte = `SFP_TBL_B31;    // R18
         8'h32: table_byte = `SFP_TBL_B32;    // R19 R20
         8'h33: table_byte = `SFP_TBL_B33;
         8'h34: table_byte = `SFP_TBL_B34;
         8'h35: table_byte = `SFP_TBL_B35;
         8'h36: table_byte = `SFP_TBL_B36;
         8'h37: table_byte = `SFP_TBL_B37;
         8'h38: table_byte = `SFP_TBL_B38;
         8'h39: table_byte = `SFP_TBL_B39;    // R21
         default: table_byte = `SFP_UNUSED;   // R22
      endcase
   endfunction : table_byte

   always_comb begin
      data_next = table_byte(rd_addr);
   end

   always_ff @(posedge clk) begin
      rd_data <= data_next;
   end

endmodule : sfp_rom

// ---- testbench/sfp_chk_sva.sv ----
// assertions on the ports of the parameter read block
// assumes bound to sfp_read; serial clock runs only inside frames
`timescale 1ns/1ps
module sfp_chk (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic busy_in,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe,
   input wire logic read_active,
   input wire logic read_rejected
);
   logic [5:0] cnt_reg;
   logic [7:0] op_reg;
   logic [7:0] idle_reg;
   // rising edges of the frame and the opcode they carried
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         cnt_reg <= 6'h00;
         op_reg  <= 8'h00;
      end else begin
         if (cnt_reg != 6'h3F) cnt_reg <= cnt_reg + 6'h01;
         if (cnt_reg < 6'h08) op_reg <= {op_reg[6:0], mosi};
      end
   end
   // clock cycles since busy_in was last high
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) idle_reg <= 8'hFF;
      else if (busy_in) idle_reg <= 8'h00;
      else if (idle_reg != 8'hFF) idle_reg <= idle_reg + 8'h01;
   end
   sequence s_active;
      ##[1:6] read_active;
   endsequence
   property p_oe_idle;
      @(posedge clk) disable iff (!rst_n) cs_n |-> !miso_oe;
   endproperty
   a_oe_idle: assert property (p_oe_idle)
      else $error("output enabled while deselected");
   property p_miso_idle;
      @(posedge clk) disable iff (!rst_n) cs_n |-> !miso;
   endproperty
   a_miso_idle: assert property (p_miso_idle)
      else $error("data line not parked while deselected");
   property p_oe_late;
      @(posedge sclk) disable iff (!rst_n) miso_oe |-> cnt_reg >= 6'h28;
   endproperty
   a_oe_late: assert property (p_oe_late)
      else $error("data driven before dummy byte ended");
   property p_oe_op;
      @(posedge sclk) disable iff (!rst_n) miso_oe |-> op_reg == 8'h5A;
   endproperty
   a_oe_op: assert property (p_oe_op)
      else $error("data driven for a foreign opcode");
   property p_excl;
      @(posedge clk) disable iff (!rst_n) !(read_active && read_rejected);
   endproperty
   a_excl: assert property (p_excl)
      else $error("read active and refused together");
   property p_active_rise;
      @(posedge clk) disable iff (!rst_n) $rose(miso_oe) |-> s_active;
   endproperty
   a_active_rise: assert property (p_active_rise)
      else $error("read status missing in data phase");
   property p_active_fall;
      @(posedge clk) disable iff (!rst_n) $rose(cs_n) |-> ##[1:6] !read_active;
   endproperty
   a_active_fall: assert property (p_active_fall)
      else $error("read status stuck after deselect");
   property p_rej_busy;
      @(posedge clk) disable iff (!rst_n)
         $rose(read_rejected) |-> idle_reg < 8'h20;
   endproperty
   a_rej_busy: assert property (p_rej_busy)
      else $error("refusal without busy");
endmodule : sfp_chk

bind sfp_read sfp_chk sfp_chk_i (.clk(clk), .rst_n(rst_n), .ce(ce),
   .busy_in(busy_in), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
   .miso_oe(miso_oe), .read_active(read_active),
   .read_rejected(read_rejected));

// ---- testbench/sfp_host.sv ----
// host serial controller model, mode 0, for the parameter read
// assumes the bench calls frame; serial clock stands still between frames
`timescale 1ns/1ps
module sfp_host (
   output logic      sclk,
   output logic      cs_n,
   output logic      mosi,
   input  wire logic miso
);
   localparam int HALF = 16;
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   // opcode, address, dummy, then nb bytes plus extra bits
   task automatic frame(input logic [7:0] op, input logic [23:0] adr,
         input int nb, input int extra, output logic [7:0] q[$]);
      logic [39:0] hdr;
      logic [7:0]  b;
      hdr = {op, adr, 8'h00};
      q = {};
      b = 8'h00;
      cs_n = 1'b0;
      for (int i = 39; i >= 0; i--) begin
         mosi = hdr[i];
         #HALF sclk = 1'b1;
         #HALF sclk = 1'b0;
      end
      mosi = ~mosi;
      for (int i = 0; i < nb * 8 + extra; i++) begin
         #HALF sclk = 1'b1;
         b = {b[6:0], miso};
         if (i % 8 == 7) q.push_back(b);
         #HALF sclk = 1'b0;
      end
      #HALF cs_n = 1'b1;
      #(2 * HALF) mosi = ~mosi;
   endtask : frame
endmodule : sfp_host

// ---- testbench/sfp_read_test.sv ----
// self-checking bench of the parameter read block
// assumes sfp_host drives the link and sfp_chk is bound to the design
`timescale 1ns/1ps
module sfp_read_test;
   logic        clk, rst_n, ce, busy_in, sclk, cs_n, mosi;
   logic        miso, miso_oe, read_active, read_rejected;
   logic        miso_line;
   int          n_errors, num_checks, cycles, oe_cnt, base;
   logic [7:0]  q[$];
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   sfp_read sfp_read_i (.clk(clk), .rst_n(rst_n), .ce(ce),
      .busy_in(busy_in), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
      .miso(miso), .miso_oe(miso_oe), .read_active(read_active),
      .read_rejected(read_rejected));
   // data line pulled up while the device does not drive it
   assign miso_line = miso_oe ? miso : 1'b1;
   sfp_host sfp_host_i (.sclk(sclk), .cs_n(cs_n), .mosi(mosi),
      .miso(miso_line));
   always @(posedge sclk) if (miso_oe === 1'b1) oe_cnt++;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         n_errors++;
         finish_test();
      end
   end
   // expected byte as {care mask, value}
   function automatic logic [15:0] exp_b(input logic [7:0] a);
      case (a)
         8'h00: return 16'hFF53;
         8'h01: return 16'hFF46;
         8'h02: return 16'hFF44;
         8'h03: return 16'hFF50;
         8'h04, 8'h06, 8'h08, 8'h09: return 16'hFF00;
         8'h05, 8'h0A: return 16'hFF01;
         8'h0B: return 16'hFF09;
         8'h0C: return 16'hFF30;
         8'h0D, 8'h0E: return 16'hFF00;
         8'h30: return 16'hFFED;
         8'h31: return 16'hFF20;
         8'h32: return 16'h0701;
         8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38: return 16'h0000;
         8'h39: return 16'hFFEB;
         default: return 16'hFFFF;
      endcase
   endfunction : exp_b
   task automatic chk(input logic [7:0] got, input logic [15:0] e);
      num_checks++;
      if ((got & e[15:8]) !== e[7:0]) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e[7:0]);
      end
   endtask : chk
   task automatic rd(input logic [23:0] a, input int nb);
      sfp_host_i.frame(8'h5A, a, nb, 0, q);
      for (int j = 0; j < nb; j++) begin
         chk(q[j], exp_b(a[7:0] + 8'(j)));
      end
   endtask : rd
   task automatic finish_test();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : finish_test
   initial begin
      ce = 1'b1;
      busy_in = 1'b0;
      rst_n = 1'b0;
      void'($urandom(32'h8A43));
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      chk({7'h00, miso_oe}, 16'hFF00);
      fork
         rd(24'h000000, 258);
         begin
            repeat (100) @(negedge clk);
            chk({7'h00, read_active}, 16'hFF01);
         end
      join
      repeat (6) @(negedge clk);
      chk({7'h00, read_active}, 16'hFF00);
      $display("test sweep done");
      rd(24'h0000FE, 3);
      for (int i = 0; i < 8; i++) rd(24'($urandom), 1 + int'($urandom % 5));
      $display("test random done");
      sfp_host_i.frame(8'h5A, 24'h00002F, 2, 3, q);
      chk(q[1], exp_b(8'h30));
      @(negedge clk);
      chk({7'h00, miso_oe}, 16'hFF00);
      rd(24'h000039, 1);
      $display("test abort done");
      base = oe_cnt;
      sfp_host_i.frame(8'h03, 24'h000000, 2, 0, q);
      chk(8'(oe_cnt - base), 16'hFF00);
      $display("test opcode done");
      @(negedge clk);
      busy_in = 1'b1;
      repeat (4) @(negedge clk);
      base = oe_cnt;
      fork
         sfp_host_i.frame(8'h5A, 24'h000000, 2, 0, q);
         begin
            repeat (2) @(negedge clk);
            ce = 1'b0;
            repeat (18) @(negedge clk);
            chk({7'h00, read_rejected}, 16'hFF00);
            ce = 1'b1;
            repeat (6) @(negedge clk);
            chk({7'h00, read_rejected}, 16'hFF01);
         end
      join
      repeat (6) @(negedge clk);
      chk(8'(oe_cnt - base), 16'hFF00);
      chk({7'h00, read_rejected}, 16'hFF00);
      busy_in = 1'b0;
      repeat (4) @(negedge clk);
      rd(24'h000000, 4);
      repeat (6) @(negedge clk);
      chk({7'h00, read_rejected}, 16'hFF00);
      $display("test busy done");
      finish_test();
   end
endmodule : sfp_read_test
